// file: pdm_pkg.sv
/*
  Shared constants for the one-bit microphone link: system clock rate, sleep and
  wake counts, stream scaling and the codec clock divider.
  Assumes a single 100 MHz system clock on both ends of the link.
*/
package pdm_pkg;

  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned SLEEP_TIME_US = 1000;
  localparam int unsigned SLEEP_CYC     = SLEEP_TIME_US * CLK_MHZ;
  localparam int unsigned WAKE_EDGES    = 32768;
  localparam int unsigned CNT_W         = 17;

  localparam int unsigned PCM_W      = 16;
  localparam int unsigned ACC_W      = 20;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned OSR        = 64;
  localparam int unsigned OSR_W      = 6;

  localparam logic signed [ACC_W-1:0] FULL_SCALE = 20'sh07FFF;
  localparam logic signed [ACC_W-1:0] PEAK_LIM   = 20'sh05A82;
  localparam logic signed [ACC_W-1:0] DC_OFFSET  = 20'sh003D7;

  localparam int unsigned PDM_HALF_NS  = 200;
  localparam int unsigned PDM_HALF_CYC = PDM_HALF_NS * CLK_MHZ / 1000;
  localparam int unsigned DIV_W        = 5;
  localparam int unsigned ONES_W       = 7;
  localparam int unsigned DEC_W        = 18;
  localparam int unsigned DEC_SHIFT    = 9;
  localparam int unsigned HPF_SHIFT    = 4;

  typedef enum logic [1:0] {
    PDM_SLEEP,
    PDM_WARM,
    PDM_RUN
  } pdm_mic_state_t;

endpackage : pdm_pkg

// file: pdm_link_if.sv
/*
  Link between the codec and up to two microphones sharing one data line.
  Assumes mic lane 0 and lane 1 are driven by separate microphone instances.
*/
interface pdm_link_if;

  logic            pdm_clk;
  wire logic [1:0] mic_oe;
  wire logic [1:0] mic_do;
  wire logic       pdm_data;

  // The joined line has no pull; released, it shows the inverse of the parked data bits.
  assign pdm_data = mic_oe[0] ? mic_do[0] :
                    mic_oe[1] ? mic_do[1] : ~(mic_do[0] | mic_do[1]);

  modport codec (output pdm_clk, input pdm_data);
  modport mic   (input pdm_clk, output mic_oe, output mic_do);

endinterface : pdm_link_if

// file: pdm_fifo.sv
/*
  Synchronous FIFO with valid and ready on both sides and registered flags.
  Assumes one clock and an active-low asynchronous reset.
*/
module pdm_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             ready_q, ready_d, valid_q, valid_d;
  logic             push, pop;

  assign push      = in_valid & ready_q;
  assign pop       = valid_q & out_ready;
  assign in_ready  = ready_q;
  assign out_valid = valid_q;
  assign out_data  = mem[rd_q];

  always_comb begin
    wr_d  = push ? PTR_W'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? PTR_W'(rd_q + 1'b1) : rd_q;
    cnt_d = CNT_W'(cnt_q + CNT_W'(push) - CNT_W'(pop));
    ready_d = (cnt_d != CNT_W'(DEPTH));
    valid_d = (cnt_d != '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      ready_q <= ready_d;
      valid_q <= valid_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

endmodule : pdm_fifo

// file: pdm_mic.sv
/*
  Microphone end: turns buffered audio samples into a one-bit density stream and
  drives it onto its half of the shared data line, with clock-driven sleep.
  Assumes the codec supplies the link clock, sampled synchronously to mclk.
*/
module pdm_mic #(
  parameter int unsigned LANE = 0,
  parameter logic [pdm_pkg::CNT_W-1:0] SLEEP_CYC  = pdm_pkg::CNT_W'(pdm_pkg::SLEEP_CYC),
  parameter logic [pdm_pkg::CNT_W-1:0] WAKE_EDGES = pdm_pkg::CNT_W'(pdm_pkg::WAKE_EDGES)
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  pdm_link_if.mic                        link,
  input  wire logic                      lr_select,
  input  wire logic                      dc_offset_en,
  input  wire logic [pdm_pkg::PCM_W-1:0] pcm_data,
  input  wire logic                      pcm_valid,
  output logic                           pcm_ready,
  output logic                           asleep
);

  import pdm_pkg::*;

  // Link clock edges, detected in the same mclk cycle that they appear.
  logic                   clk_prev_q, clk_prev_d;
  logic                   rise, fall;
  logic                   launch, release_line;

  // Power state and its counters.
  pdm_mic_state_t         state_q, state_d;
  logic [CNT_W-1:0]       idle_q, idle_d;
  logic [CNT_W-1:0]       wake_q, wake_d;
  logic                   asleep_q, asleep_d;

  // Modulator and line driver.
  logic signed [ACC_W-1:0] acc_q, acc_d;
  logic signed [PCM_W-1:0] smp_q, smp_d;
  logic [OSR_W-1:0]        osr_q, osr_d;
  logic                    oe_q, oe_d;
  logic                    do_q, do_d;
  logic signed [ACC_W-1:0] smp_ext, x_lim, x_in, fb;
  logic                    bit_now;

  // Sample buffer.
  logic [PCM_W-1:0]        f_data;
  logic                    f_valid;
  logic                    take;

  pdm_fifo #(
    .WIDTH (PCM_W),
    .DEPTH (FIFO_DEPTH)
  ) i_pdm_fifo (
    .clk       (mclk),
    .rst_n     (rst_n),
    .in_data   (pcm_data),
    .in_valid  (pcm_valid),
    .in_ready  (pcm_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (take)
  );

  assign rise = link.pdm_clk & ~clk_prev_q;
  assign fall = ~link.pdm_clk & clk_prev_q;

  // Each channel owns one half of the clock period.
  assign launch       = lr_select ? fall : rise;
  assign release_line = lr_select ? rise : fall;

  assign take = (state_q == PDM_RUN) && launch && (osr_q == OSR_W'(OSR - 1));

  always_comb begin
    clk_prev_d = link.pdm_clk;
    state_d    = state_q;
    wake_d     = wake_q;
    // Idle time since the last rising edge; saturates at the sleep limit.
    if (rise) begin
      idle_d = '0;
    end else if (idle_q == SLEEP_CYC) begin
      idle_d = idle_q;
    end else begin
      idle_d = CNT_W'(idle_q + 1'b1);
    end
    unique case (state_q)
      PDM_SLEEP: begin
        if (rise) begin
          state_d = PDM_WARM;
          wake_d  = CNT_W'(1);
        end
      end
      PDM_WARM: begin
        if (idle_q == SLEEP_CYC) begin
          state_d = PDM_SLEEP;
          wake_d  = '0;
        end else if (wake_q == WAKE_EDGES) begin
          state_d = PDM_RUN;
        end else if (rise) begin
          wake_d = CNT_W'(wake_q + 1'b1);
        end
      end
      PDM_RUN: begin
        if (idle_q == SLEEP_CYC) begin
          state_d = PDM_SLEEP;
          wake_d  = '0;
        end
      end
    endcase
    asleep_d = (state_d == PDM_SLEEP);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b0;
      state_q    <= PDM_WARM;
      idle_q     <= '0;
      wake_q     <= '0;
      asleep_q   <= 1'b0;
    end else begin
      clk_prev_q <= clk_prev_d;
      state_q    <= state_d;
      idle_q     <= idle_d;
      wake_q     <= wake_d;
      asleep_q   <= asleep_d;
    end
  end

  assign asleep = asleep_q;

  // Code 7FFF stands for 140 dB SPL peak, so 94 dB SPL peaks at -46 dBFS.
  assign smp_ext = ACC_W'(smp_q);

  always_comb begin
    // Peak limit near -3 dBFS, then the optional constant offset.
    if (smp_ext > PEAK_LIM) begin
      x_lim = PEAK_LIM;
    end else if (smp_ext < -PEAK_LIM) begin
      x_lim = -PEAK_LIM;
    end else begin
      x_lim = smp_ext;
    end
    x_in    = dc_offset_en ? ACC_W'(x_lim + DC_OFFSET) : x_lim;
    // First-order loop: ones density tracks x_in; zero gives 1010.
    bit_now = ~acc_q[ACC_W-1];
    fb      = bit_now ? FULL_SCALE : -FULL_SCALE;
    acc_d   = acc_q;
    smp_d   = smp_q;
    osr_d   = osr_q;
    oe_d    = oe_q;
    do_d    = do_q;
    if (state_q != PDM_RUN) begin
      acc_d = '0;
      osr_d = '0;
      oe_d  = 1'b0;
      do_d  = 1'b0;
    end else if (launch) begin
      acc_d = ACC_W'(acc_q + x_in - fb);
      osr_d = OSR_W'(osr_q + 1'b1);
      oe_d  = 1'b1;
      do_d  = bit_now;
      if (take && f_valid) begin
        smp_d = f_data;
      end
    end else if (release_line) begin
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      smp_q <= '0;
      osr_q <= '0;
      oe_q  <= 1'b0;
      do_q  <= 1'b0;
    end else begin
      acc_q <= acc_d;
      smp_q <= smp_d;
      osr_q <= osr_d;
      oe_q  <= oe_d;
      do_q  <= do_d;
    end
  end

  assign link.mic_oe[LANE] = oe_q;
  assign link.mic_do[LANE] = do_q;

endmodule : pdm_mic

// file: pdm_codec.sv
/*
  Codec end: makes the link clock by division, captures both channel slots from
  the shared line, and decimates each with a boxcar and a high-pass stage.
  Assumes microphones answer within a few mclk of each link clock edge.
*/
module pdm_codec (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  pdm_link_if.codec                      link,
  input  wire logic                      clk_run,
  output logic                           left_slot_bit,
  output logic                           right_slot_bit,
  output logic                           left_bit_valid,
  output logic                           right_bit_valid,
  output logic [pdm_pkg::PCM_W-1:0]      left_pcm,
  output logic [pdm_pkg::PCM_W-1:0]      right_pcm,
  output logic                           pcm_valid
);

  import pdm_pkg::*;

  logic [DIV_W-1:0]         div_q, div_d;
  logic                     clk_q, clk_d, fell_q, fell_d;
  logic                     lbit_q, lbit_d, rbit_q, rbit_d, lv_q, lv_d, rv_q, rv_d;
  logic [OSR_W-1:0]         cnt_q, cnt_d;
  logic [ONES_W-1:0]        ones_q [2];
  logic [ONES_W-1:0]        ones_d [2];
  logic signed [DEC_W-1:0]  avg_q [2];
  logic signed [DEC_W-1:0]  avg_d [2];
  logic signed [DEC_W-1:0]  v, diff;
  logic [PCM_W-1:0]         pcm_q [2];
  logic [PCM_W-1:0]         pcm_d [2];
  logic                     pv_q, pv_d, end_half;

  assign end_half = (div_q == DIV_W'(PDM_HALF_CYC - 1));

  always_comb begin
    div_d  = end_half ? '0 : DIV_W'(div_q + 1'b1);
    // The clock stops low when not running; a high half always completes.
    clk_d  = (end_half && (clk_q || clk_run)) ? ~clk_q : clk_q;
    fell_d = (end_half && clk_q) ? 1'b1 : ((end_half && !clk_q) ? 1'b0 : fell_q);
    lbit_d = lbit_q;
    rbit_d = rbit_q;
    lv_d   = 1'b0;
    rv_d   = 1'b0;
    cnt_d  = cnt_q;
    pv_d   = 1'b0;
    ones_d = ones_q;
    avg_d  = avg_q;
    pcm_d  = pcm_q;
    v      = '0;
    diff   = '0;
    // Capture each slot at the end of the half its owner launched in.
    if (end_half && clk_q) begin
      rbit_d    = link.pdm_data;
      rv_d      = 1'b1;
      ones_d[1] = ONES_W'(ones_q[1] + ONES_W'(link.pdm_data));
    end
    if (end_half && !clk_q && fell_q) begin
      lbit_d    = link.pdm_data;
      lv_d      = 1'b1;
      ones_d[0] = ONES_W'(ones_q[0] + ONES_W'(link.pdm_data));
      cnt_d     = OSR_W'(cnt_q + 1'b1);
      if (cnt_q == OSR_W'(OSR - 1)) begin
        pv_d = 1'b1;
        for (int c = 0; c < 2; c++) begin
          v        = DEC_W'((DEC_W'(ones_d[c]) - DEC_W'(OSR / 2)) <<< DEC_SHIFT);
          diff     = DEC_W'(v - avg_q[c]);
          avg_d[c] = DEC_W'(avg_q[c] + (diff >>> HPF_SHIFT));
          pcm_d[c] = diff[PCM_W-1:0];
          ones_d[c] = '0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= '0;
      clk_q  <= 1'b0;
      fell_q <= 1'b0;
      lbit_q <= 1'b0;
      rbit_q <= 1'b0;
      lv_q   <= 1'b0;
      rv_q   <= 1'b0;
      cnt_q  <= '0;
      pv_q   <= 1'b0;
      ones_q <= '{default: '0};
      avg_q  <= '{default: '0};
      pcm_q  <= '{default: '0};
    end else begin
      div_q  <= div_d;
      clk_q  <= clk_d;
      fell_q <= fell_d;
      lbit_q <= lbit_d;
      rbit_q <= rbit_d;
      lv_q   <= lv_d;
      rv_q   <= rv_d;
      cnt_q  <= cnt_d;
      pv_q   <= pv_d;
      ones_q <= ones_d;
      avg_q  <= avg_d;
      pcm_q  <= pcm_d;
    end
  end

  assign link.pdm_clk    = clk_q;
  assign left_slot_bit   = lbit_q;
  assign right_slot_bit  = rbit_q;
  assign left_bit_valid  = lv_q;
  assign right_bit_valid = rv_q;
  assign left_pcm        = pcm_q[0];
  assign right_pcm       = pcm_q[1];
  assign pcm_valid       = pv_q;

endmodule : pdm_codec

// file: pdm_link_chk.sv
/*
  Checker for the shared one-bit microphone line: launch edges, release, sleep and wake count.
  Assumes lane 0 is set to the left slot and lane 1 to the right slot.
*/
module pdm_link_chk #(
  parameter int SLEEP_CYC  = 200,
  parameter int WAKE_EDGES = 8
) (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       pdm_clk,
  input wire logic [1:0] mic_oe,
  input wire logic [1:0] mic_do
);
  timeunit 1ns;
  timeprecision 1ns;

  logic        rise;
  logic        clk_prev_q;
  logic        clk_prev_d;
  logic [15:0] idle_q;
  logic [15:0] idle_d;
  logic [7:0]  rises_q;
  logic [7:0]  rises_d;

  // Counts cycles since the last link clock rise and rises since the last long stop.
  always_comb begin
    rise       = pdm_clk && !clk_prev_q;
    clk_prev_d = pdm_clk;
    idle_d     = rise ? 16'h0000 : idle_q + 16'(idle_q != 16'hFFFF);
    rises_d    = rises_q + 8'(rise && rises_q != 8'hFF);
    if (idle_q >= 16'(SLEEP_CYC)) begin
      rises_d = 8'(rise);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b0;
      idle_q     <= 16'h0000;
      rises_q    <= 8'h00;
    end else begin
      clk_prev_q <= clk_prev_d;
      idle_q     <= idle_d;
      rises_q    <= rises_d;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_left_on_fall: assert property (
    $rose(mic_oe[0]) |-> !$past(pdm_clk, 1) && $past(pdm_clk, 2))
    else $error("left lane drive did not follow a falling clock");
  a_right_on_rise: assert property (
    $rose(mic_oe[1]) |-> $past(pdm_clk, 1) && !$past(pdm_clk, 2))
    else $error("right lane drive did not follow a rising clock");
  a_left_release: assert property ($rose(pdm_clk) |-> ##2 !mic_oe[0])
    else $error("left lane still drives after its half");
  a_right_release: assert property ($fell(pdm_clk) |-> ##2 !mic_oe[1])
    else $error("right lane still drives after its half");
  a_lanes_apart: assert property (!(mic_oe[0] && mic_oe[1]))
    else $error("both lanes drive the line");
  a_left_hold: assert property ($rose(mic_oe[0]) |-> mic_oe[0] [*8])
    else $error("left lane drive too short");
  a_bit_steady: assert property (
    mic_oe[0] && $past(mic_oe[0]) |-> $stable(mic_do[0]))
    else $error("left bit changed within its half");
  a_sleep_quiet: assert property (
    idle_q >= 16'(SLEEP_CYC + 4) |-> mic_oe == 2'b00)
    else $error("line driven while clock stopped");
  a_wake_count: assert property (
    $rose(mic_oe[0]) || $rose(mic_oe[1]) |-> rises_q >= 8'(WAKE_EDGES))
    else $error("line driven before the wake count");

endmodule : pdm_link_chk

// file: tb_pdm_mic_output_sleep_wake.sv
/*
  Testbench: two microphone ends and one codec end joined by the link interface.
  Assumes lane 0 is the left slot, lane 1 the right slot, with shortened sleep and wake counts.
*/
module tb_pdm_mic_output_sleep_wake;
  timeunit 1ns;
  timeprecision 1ns;
  import pdm_pkg::*;

  logic             mclk;
  logic             rst_n;
  logic             clk_run;
  logic             dc_en;
  logic [1:0]       pv;
  logic [1:0]       pr;
  logic [1:0]       slp;
  logic [PCM_W-1:0] pd [2];
  logic             l_bit, r_bit, l_vld, r_vld, p_vld;
  logic [PCM_W-1:0] l_pcm, r_pcm;
  int               n_fail, checks_done, l1, r1, lc, np;

  pdm_link_if i_pdm_link_if ();

  for (genvar g = 0; g < 2; g++) begin : g_mic
    pdm_mic #(.LANE(g), .SLEEP_CYC(17'h000C8), .WAKE_EDGES(17'h00008)) i_pdm_mic (
      .mclk(mclk), .rst_n(rst_n), .link(i_pdm_link_if), .lr_select(g == 0),
      .dc_offset_en(dc_en), .pcm_data(pd[g]), .pcm_valid(pv[g]), .pcm_ready(pr[g]),
      .asleep(slp[g]));
  end

  pdm_codec i_pdm_codec (
    .mclk(mclk), .rst_n(rst_n), .link(i_pdm_link_if), .clk_run(clk_run),
    .left_slot_bit(l_bit), .right_slot_bit(r_bit), .left_bit_valid(l_vld),
    .right_bit_valid(r_vld), .left_pcm(l_pcm), .right_pcm(r_pcm), .pcm_valid(p_vld));

  pdm_link_chk #(.SLEEP_CYC(200), .WAKE_EDGES(8)) i_pdm_link_chk (
    .mclk(mclk), .rst_n(rst_n), .pdm_clk(i_pdm_link_if.pdm_clk),
    .mic_oe(i_pdm_link_if.mic_oe), .mic_do(i_pdm_link_if.mic_do));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : check

  task automatic push(input logic [PCM_W-1:0] w0, input logic [PCM_W-1:0] w1);
    logic [1:0] t;
    @(posedge mclk);
    pd[0] <= w0;
    pd[1] <= w1;
    pv    <= 2'b11;
    for (int i = 0; i < 5000; i++) begin
      @(negedge mclk);
      if (pv == 2'b00) break;
      t = pv & pr;
      @(posedge mclk);
      pv <= pv & ~t;
    end
  endtask : push

  task automatic count_bits(input int n);
    int   nl;
    logic lp;
    nl = 0;
    l1 = 0;
    r1 = 0;
    lc = 0;
    np = 0;
    lp = 1'bx;
    for (int c = 0; c < n * 45 && nl < n; c++) begin
      @(negedge mclk);
      if (l_vld === 1'b1) begin
        nl++;
        l1 += int'(l_bit === 1'b1);
        lc += int'(l_bit === ~lp);
        lp = l_bit;
      end
      r1 += int'(r_vld === 1'b1 && r_bit === 1'b1);
      np += int'(p_vld === 1'b1);
    end
  endtask : count_bits

  task automatic measure(input int n);
    count_bits(96);
    count_bits(n);
  endtask : measure

  task automatic measure_wake();
    int   rises;
    int   first [2];
    logic cp;
    rises = 0;
    first = '{-1, -1};
    cp    = 1'b0;
    for (int c = 0; c < 1000 && first[1] < 0; c++) begin
      @(negedge mclk);
      rises += int'(i_pdm_link_if.pdm_clk === 1'b1 && cp === 1'b0);
      cp = i_pdm_link_if.pdm_clk;
      for (int k = 0; k < 2; k++) begin
        if (first[k] < 0 && i_pdm_link_if.mic_oe[k] === 1'b1) first[k] = rises;
      end
    end
    check("left wake rises", 8, 8, first[0]);
    check("right wake rises", 9, 9, first[1]);
  endtask : measure_wake

  initial begin
    #1000000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    int n0, n1;
    n_fail = 0;
    checks_done = 0;
    rst_n = 1'b0;
    clk_run = 1'b1;
    dc_en = 1'b0;
    pv = 2'b00;
    pd = '{16'h0000, 16'h0000};
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    measure_wake();
    push(16'h0000, 16'h0000);
    measure(64);
    check("left zero ones", 32, 32, l1);
    check("left zero changes", 63, 63, lc);
    check("right zero ones", 31, 33, r1);
    push(16'h4000, 16'hC000);
    measure(64);
    check("left half ones", 47, 49, l1);
    check("right half ones", 15, 17, r1);
    push(16'h7FFF, 16'h8000);
    measure(64);
    check("left peak ones", 53, 56, l1);
    check("right peak ones", 8, 11, r1);
    // The next decimated frame lies wholly inside the peak samples.
    for (int c = 0; c < 3000 && p_vld !== 1'b1; c++) begin
      @(negedge mclk);
    end
    n0 = int'($signed(l_pcm)) - int'($signed(r_pcm));
    check("peak frame seen", 1, 1, int'(p_vld === 1'b1));
    check("peak pcm spread", 10000, 24000, n0);
    push(16'h0000, 16'h0000);
    @(posedge mclk);
    dc_en <= 1'b1;
    measure(256);
    check("left offset ones", 130, 134, l1);
    check("frames", 3, 5, np);
    @(posedge mclk);
    clk_run <= 1'b0;
    repeat (240) @(posedge mclk);
    @(negedge mclk);
    check("asleep", 1, 1, int'(slp === 2'b11));
    check("line released", 1, 1, int'(i_pdm_link_if.mic_oe === 2'b00));
    @(posedge mclk);
    clk_run <= 1'b1;
    dc_en <= 1'b0;
    measure_wake();
    check("awake", 1, 1, int'(slp === 2'b00));
    count_bits(32);
    check("restart changes", 31, 31, lc);
    check("restart ones", 16, 16, l1);
    n0 = 0;
    n1 = 0;
    @(posedge mclk);
    pv <= 2'b11;
    repeat (30) begin
      @(negedge mclk);
      n0 += int'(pr[0] === 1'b1);
      n1 += int'(pr[1] === 1'b1);
    end
    check("fifo refuses", 1, 1, int'(pr === 2'b00));
    @(posedge mclk);
    pv <= 2'b00;
    check("fifo words left", 16, 17, n0);
    check("fifo words right", 16, 17, n1);
    tally_and_finish();
  end

endmodule : tb_pdm_mic_output_sleep_wake
